// File: dis_map.vh
// constants for the interrupt section builder
`ifndef DIS_MAP_VH
`define DIS_MAP_VH
`define DIS_SEC_MAX_BYTES 5'd20
`define DIS_START_PLAIN 8'h09
`define DIS_START_ENH 8'h10
`define DIS_CHAN_DIAG_LEN 8'h03
`define DIS_HDR_BYTES 5'd4
`define DIS_DIAG_REC_BYTES 5'd16
`define DIS_HW_INFO_BYTES 5'd4
`define DIS_BASE_SLOT 8'h02
`define DIS_NEW_X5 8'h1B
`define DIS_NEW_X9 8'h08
`define DIS_NEW_X10 8'h08
`define DIS_BASE_LEN_NEW 5'd20
`define DIS_BASE_LEN_OLD 5'd8
`define DIS_EXT_FAULT 5'b1_1010
`define DIS_BIT_GEN 0
`define DIS_BIT_INT 1
`define DIS_BIT_CFG 2
`define DIS_BIT_INACC 3
`define DIS_BIT_LOAD 4
`define DIS_BIT_UNPAR 6
`define DIS_BIT_PARM 7
`define DIS_KIND_DIAG 2'b01
`define DIS_KIND_HW 2'b10
`define DIS_KIND_BASE 2'b11
`define DIS_FIFO_DEPTH 32
`endif

// File: dis_fifo.v
// synchronous byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module dis_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire sys_clk,
	input wire nrst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// full and empty taken straight from the occupancy count
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage has no reset, only the pointers and the count do
	always @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointer and count bookkeeping
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // dis_fifo

// File: dis_flags.v
// base unit error-flag byte encoder, new and old layouts
`timescale 1ns/1ps
`include "dis_map.vh"
module dis_flags (
	input wire old_layout,
	input wire err_internal,
	input wire err_config,
	input wire err_inaccessible,
	input wire err_load,
	input wire err_unparam,
	input wire err_param,
	input wire logic_supply_low,
	output reg [7:0] flag_byte
);
	// new layout keeps every err cause but not logic_supply_low, old layout folds malfunction into bit 0
	always @*
	begin
		flag_byte = 8'h00;
		if (old_layout)
		begin
			flag_byte[`DIS_BIT_CFG] = err_config;
			flag_byte[`DIS_BIT_LOAD] = err_load;
			flag_byte[`DIS_BIT_PARM] = err_param;
			flag_byte[`DIS_BIT_GEN] = logic_supply_low | (err_config & err_load);
		end
		else
		begin
			flag_byte[`DIS_BIT_INT] = err_internal;
			flag_byte[`DIS_BIT_CFG] = err_config;
			flag_byte[`DIS_BIT_INACC] = err_inaccessible;
			flag_byte[`DIS_BIT_LOAD] = err_load;
			flag_byte[`DIS_BIT_UNPAR] = err_unparam;
			flag_byte[`DIS_BIT_PARM] = err_param;
			flag_byte[`DIS_BIT_GEN] = err_internal | err_config | err_inaccessible | err_load
				| err_unparam | err_param;
		end
	end
endmodule // dis_flags

// File: dis_builder.v
// builds the interrupt section of a slave diagnostic frame as a byte stream
`timescale 1ns/1ps
`include "dis_map.vh"
module dis_builder (
	input wire sys_clk,
	input wire nrst,
	input wire irq_valid,
	input wire [1:0] irq_kind,
	input wire [7:0] irq_type,
	input wire [7:0] irq_slot,
	input wire [7:0] irq_spec,
	input wire [127:0] irq_record,
	input wire [31:0] irq_hw_info,
	input wire irq_from_expansion_unit,
	input wire base_old_layout,
	input wire err_internal,
	input wire err_config,
	input wire err_inaccessible,
	input wire err_load,
	input wire err_unparam,
	input wire err_param,
	input wire logic_supply_low,
	input wire enhanced_diag,
	input wire [3:0] chan_diag_count,
	input wire frame_req,
	output reg [7:0] sec_start_reg,
	output reg [4:0] sec_len_reg,
	output reg irq_pending_reg,
	output reg [4:0] chan_err_type_reg,
	output reg chan_err_valid_reg,
	output reg busy_reg,
	output reg [7:0] out_data_reg,
	output reg out_valid_reg,
	output reg out_last_reg,
	input wire out_ready
);
	localparam ST_IDLE = 3'b001;
	localparam ST_FILL = 3'b010;
	localparam ST_DRAIN = 3'b100;

	reg [7:0] sec_reg [0:19];
	reg [4:0] len_reg;
	reg [2:0] state_reg;
	reg [4:0] idx_reg;
	reg [4:0] left_reg;
	reg [7:0] fifo_in;
	reg fifo_in_valid;
	reg fifo_in_last;
	wire fifo_in_ready;
	wire [8:0] fifo_out;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [7:0] flag_byte;
	wire [7:0] start_next;
	reg [4:0] len_next;

	// section image pieces and shared strobes
	wire [7:0] enh_start;
	wire take_irq;
	wire frame_go;
	wire drain_done;
	wire [7:0] slot_sel;
	wire [7:0] base_x5;
	wire [7:0] base_x9;
	wire [7:0] base_x10;
	wire [31:0] hdr_bytes;
	wire [127:0] hw_bytes;
	wire [127:0] base_bytes;
	wire [159:0] sec_img;
	genvar g;
	integer i;

	dis_flags u_flags (
		.old_layout(base_old_layout),
		.err_internal(err_internal),
		.err_config(err_config),
		.err_inaccessible(err_inaccessible),
		.err_load(err_load),
		.err_unparam(err_unparam),
		.err_param(err_param),
		.logic_supply_low(logic_supply_low),
		.flag_byte(flag_byte)
	);

	// strobes shared by the capture and the sequencer
	// capture only while idle, so one frame never carries two interrupts
	assign take_irq = irq_valid && (state_reg == ST_IDLE);
	// a frame waits out a capture in the same cycle so it streams the newest section
	assign frame_go = frame_req && irq_pending_reg && !irq_valid && (state_reg == ST_IDLE);
	// section fully handed over once the copy is done and the fifo is empty
	assign drain_done = (state_reg == ST_DRAIN) && (left_reg == 5'd0) && !fifo_out_valid;

	// start byte: fixed at nine, or after the status block and the three-byte channel entries
	assign enh_start = `DIS_START_ENH + {3'b000, chan_diag_count, 1'b0} + {4'h0, chan_diag_count};
	assign start_next = enhanced_diag ? enh_start : `DIS_START_PLAIN;

	// section length per interrupt kind, capped at the section maximum
	always @*
	begin
		case (irq_kind)
			`DIS_KIND_DIAG: len_next = `DIS_HDR_BYTES + `DIS_DIAG_REC_BYTES;
			`DIS_KIND_HW: len_next = `DIS_HDR_BYTES + `DIS_HW_INFO_BYTES;
			`DIS_KIND_BASE: len_next = base_old_layout ? `DIS_BASE_LEN_OLD : `DIS_BASE_LEN_NEW;
			default: len_next = `DIS_HDR_BYTES;
		endcase
		if (len_next > `DIS_SEC_MAX_BYTES)
			len_next = `DIS_SEC_MAX_BYTES;
	end

	// header bytes: length, type, slot, specifier; base unit sections always name slot two
	assign slot_sel = (irq_kind == `DIS_KIND_BASE) ? `DIS_BASE_SLOT : irq_slot;
	assign hdr_bytes = {irq_spec, slot_sel, irq_type, 3'b000, len_next};

	// hardware info fills four body bytes, the rest of the body stays zero
	assign hw_bytes = {96'h0, irq_hw_info};

	// base unit body: flags at x+4, fixed bytes only in the new layout, old layout leaves them zero
	assign base_x5 = base_old_layout ? 8'h00 : `DIS_NEW_X5;
	assign base_x9 = base_old_layout ? 8'h00 : `DIS_NEW_X9;
	assign base_x10 = base_old_layout ? 8'h00 : `DIS_NEW_X10;
	assign base_bytes = {72'h0, base_x10, base_x9, 24'h0, base_x5, flag_byte};

	// section image, one byte position per entry; unused positions come out zero
	generate
		for (g = 0; g < 20; g = g + 1)
		begin : g_img
			if (g < 4)
			begin : g_hdr
				// header positions pass straight through
				assign sec_img[8*g +: 8] = hdr_bytes[8*g +: 8];
			end
			else
			begin : g_body
				wire [7:0] diag_byte;
				wire [7:0] hw_byte;
				wire [7:0] base_byte;
				assign diag_byte = irq_record[8*(g-4) +: 8];
				assign hw_byte = hw_bytes[8*(g-4) +: 8];
				assign base_byte = base_bytes[8*(g-4) +: 8];
				// only the captured kind's bytes survive
				assign sec_img[8*g +: 8] = (irq_kind == `DIS_KIND_DIAG) ? diag_byte :
					(irq_kind == `DIS_KIND_HW) ? hw_byte :
					(irq_kind == `DIS_KIND_BASE) ? base_byte :
					8'h00;
			end
		end
	endgenerate

	// section store; a capture rewrites every position, so a shorter section never inherits old bytes
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (i = 0; i < 20; i = i + 1)
				sec_reg[i] <= 8'h00;
		end
		else if (take_irq)
		begin
			for (i = 0; i < 20; i = i + 1)
				sec_reg[i] <= sec_img[8*i +: 8];
		end
	end

	// capture of the latest interrupt; a new one replaces the held section, no queue
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			len_reg <= 5'd0;
			irq_pending_reg <= 1'b0;
			sec_start_reg <= `DIS_START_PLAIN;
			sec_len_reg <= 5'd0;
			chan_err_type_reg <= 5'd0;
			chan_err_valid_reg <= 1'b0;
		end
		else
		begin
			sec_start_reg <= start_next;
			if (take_irq)
			begin
				len_reg <= len_next;
				sec_len_reg <= len_next;
				irq_pending_reg <= 1'b1;
				chan_err_valid_reg <= (irq_kind == `DIS_KIND_DIAG) && irq_from_expansion_unit;
				chan_err_type_reg <= `DIS_EXT_FAULT;
			end
			else if (drain_done)
				irq_pending_reg <= 1'b0;
		end
	end

	// frame sequencer: copy the section into the fifo, then wait for drain
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_IDLE;
			idx_reg <= 5'd0;
			left_reg <= 5'd0;
			fifo_in <= 8'h00;
			fifo_in_valid <= 1'b0;
			fifo_in_last <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (frame_go)
					begin
						state_reg <= ST_FILL;
						idx_reg <= 5'd0;
						left_reg <= len_reg;
						busy_reg <= 1'b1;
					end
				end
				ST_FILL:
				begin
					// back-pressure from the fifo stalls the copy
					if (!fifo_in_valid || fifo_in_ready)
					begin
						if (left_reg != 5'd0)
						begin
							fifo_in <= sec_reg[idx_reg];
							fifo_in_valid <= 1'b1;
							fifo_in_last <= (left_reg == 5'd1);
							idx_reg <= idx_reg + 5'd1;
							left_reg <= left_reg - 5'd1;
						end
						else
						begin
							fifo_in_valid <= 1'b0;
							fifo_in_last <= 1'b0;
							state_reg <= ST_DRAIN;
						end
					end
				end
				ST_DRAIN:
				begin
					if (!fifo_out_valid)
					begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	dis_fifo #(
		.WIDTH(9),
		.DEPTH(`DIS_FIFO_DEPTH),
		.AW(5)
	) u_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.in_data({fifo_in_last, fifo_in}),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);

	// registered output stage; takes a byte when empty or when consumer takes one
	assign fifo_out_ready = !out_valid_reg || out_ready;

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_data_reg <= 8'h00;
			out_valid_reg <= 1'b0;
			out_last_reg <= 1'b0;
		end
		else if (fifo_out_ready)
		begin
			out_valid_reg <= fifo_out_valid;
			out_data_reg <= fifo_out_valid ? fifo_out[7:0] : 8'h00;
			out_last_reg <= fifo_out_valid & fifo_out[8];
		end
	end
endmodule // dis_builder

// File: dis_builder_assertions.sv
// port-level checks for the interrupt section builder
`timescale 1ns/1ps
module dis_builder_assertions (
	input wire sys_clk,
	input wire nrst,
	input wire irq_valid,
	input wire [1:0] irq_kind,
	input wire enhanced_diag,
	input wire [3:0] chan_diag_count,
	input wire frame_req,
	input wire [7:0] sec_start_reg,
	input wire [4:0] sec_len_reg,
	input wire irq_pending_reg,
	input wire [4:0] chan_err_type_reg,
	input wire chan_err_valid_reg,
	input wire busy_reg,
	input wire out_valid_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// a request is only taken while idle
	sequence s_take;
		irq_valid && !busy_reg;
	endsequence
	sequence s_go;
		frame_req && irq_pending_reg && !irq_valid && !busy_reg;
	endsequence
	len_max_a: assert property (sec_len_reg <= 5'd20) else $error("section too long");
	start_plain_a: assert property (!enhanced_diag |=> sec_start_reg == 8'h09) else $error("bad plain start");
	start_enh_a: assert property (enhanced_diag |=> sec_start_reg == 8'h10 + 8'(3 * $past(chan_diag_count)))
		else $error("bad enhanced start");
	capture_new_a: assert property (s_take |=> irq_pending_reg) else $error("interrupt not held");
	diag_len_a: assert property (s_take and irq_kind == 2'b01 |=> sec_len_reg == 5'd20) else $error("diag length");
	hw_len_a: assert property (s_take and irq_kind == 2'b10 |=> sec_len_reg == 5'd8) else $error("hw length");
	ext_fault_a: assert property (chan_err_valid_reg |-> chan_err_type_reg == 5'b1_1010) else $error("fault code");
	busy_refuse_a: assert property (busy_reg && irq_valid |=> $stable(sec_len_reg)) else $error("taken while busy");
	stream_go_a: assert property (s_go |=> busy_reg ##[1:4] out_valid_reg) else $error("stream did not start");
endmodule // dis_builder_assertions

// File: dis_master_model.sv
// bus master side: reads the section bytes, may stall
`timescale 1ns/1ps
module dis_master_model (
	input wire sys_clk,
	input wire [7:0] out_data_reg,
	input wire out_valid_reg,
	input wire out_last_reg,
	input wire stall,
	input wire clear,
	output reg out_ready
);
	reg [7:0] rx [0:31];
	integer rx_n;
	reg got_last;
	initial
	begin
		out_ready = 1'b1;
		rx_n = 0;
		got_last = 1'b0;
	end
	// alternate stalls so held bytes get exercised; one section per read
	always @(posedge sys_clk)
	begin
		out_ready <= stall ? ~out_ready : 1'b1;
		if (clear)
		begin
			rx_n <= 0;
			got_last <= 1'b0;
		end
		else if (out_valid_reg && out_ready && rx_n < 32)
		begin
			rx[rx_n] <= out_data_reg;
			rx_n <= rx_n + 1;
			got_last <= out_last_reg;
		end
	end
endmodule // dis_master_model

// File: dis_builder_bench.sv
// self-checking bench for the interrupt section builder
`timescale 1ns/1ps
module dis_builder_bench;
	reg sys_clk, nrst, irq_valid, irq_from_expansion_unit, base_old_layout, enhanced_diag, frame_req, stall;
	reg [1:0] irq_kind;
	reg [7:0] irq_type, irq_slot, irq_spec;
	reg [127:0] irq_record;
	reg [31:0] irq_hw_info;
	reg [6:0] errs;
	reg [3:0] chan_diag_count;
	wire [7:0] sec_start_reg, out_data_reg;
	wire [4:0] sec_len_reg, chan_err_type_reg;
	wire irq_pending_reg, chan_err_valid_reg, busy_reg, out_valid_reg, out_last_reg, out_ready;
	reg [7:0] exp [0:19];
	integer n_mismatch, samples_checked, cyc, tick, i;
	dis_builder i_dis_builder (.sys_clk, .nrst, .irq_valid, .irq_kind, .irq_type, .irq_slot, .irq_spec,
		.irq_record, .irq_hw_info, .irq_from_expansion_unit, .base_old_layout, .err_internal(errs[0]),
		.err_config(errs[1]), .err_inaccessible(errs[2]), .err_load(errs[3]), .err_unparam(errs[4]),
		.err_param(errs[5]), .logic_supply_low(errs[6]), .enhanced_diag, .chan_diag_count, .frame_req,
		.sec_start_reg, .sec_len_reg, .irq_pending_reg, .chan_err_type_reg, .chan_err_valid_reg, .busy_reg,
		.out_data_reg, .out_valid_reg, .out_last_reg, .out_ready);
	dis_master_model i_dis_master_model (.sys_clk, .out_data_reg, .out_valid_reg, .out_last_reg, .stall,
		.clear(frame_req), .out_ready);
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input [7:0] seen, input [7:0] want);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== want)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk)
	begin
		tick = tick + 1;
		if (tick == 5000)
		begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end
	task take(input [1:0] k);
	begin
		irq_kind <= k;
		irq_valid <= 1'b1;
		@(posedge sys_clk) irq_valid <= 1'b0;
		@(posedge sys_clk);
	end
	endtask
	task hdr(input [7:0] n, input [7:0] s);
	begin
		for (i = 0; i < 20; i = i + 1)
			exp[i] = 8'h00;
		exp[0] = n;
		exp[1] = irq_type;
		exp[2] = s;
		exp[3] = irq_spec;
	end
	endtask
	// read one section; a refused request is thrown in while busy
	task send(input integer n);
	begin
		frame_req <= 1'b1;
		@(posedge sys_clk) frame_req <= 1'b0;
		@(posedge sys_clk) irq_valid <= 1'b1;
		@(posedge sys_clk) irq_valid <= 1'b0;
		cyc = 0;
		while (!i_dis_master_model.got_last && cyc < 200)
		begin
			@(posedge sys_clk);
			cyc = cyc + 1;
		end
		repeat (4) @(posedge sys_clk);
		chk({7'h00, i_dis_master_model.got_last}, 8'h01);
		chk(i_dis_master_model.rx_n[7:0], n[7:0]);
		for (i = 0; i < n; i = i + 1)
			chk(i_dis_master_model.rx[i], exp[i]);
		chk({7'h00, irq_pending_reg}, 8'h00);
	end
	endtask
	task t_diag;
	begin
		for (i = 0; i < 16; i = i + 1)
			irq_record[8*i +: 8] <= 8'h10 + i[7:0];
		irq_from_expansion_unit <= 1'b1;
		take(2'b01);
		chk({3'h0, chan_err_type_reg}, 8'h1a);
		chk({7'h00, chan_err_valid_reg}, 8'h01);
		chk(sec_start_reg, 8'h09);
		hdr(8'd20, irq_slot);
		for (i = 0; i < 16; i = i + 1)
			exp[4+i] = 8'h10 + i[7:0];
		send(20);
	end
	endtask
	task t_replace;
	begin
		take(2'b01);
		irq_hw_info <= 32'hc3d2_e1f0;
		take(2'b10);
		chk({7'h00, chan_err_valid_reg}, 8'h00);
		chk({3'h0, sec_len_reg}, 8'h08);
		hdr(8'd8, irq_slot);
		{exp[7], exp[6], exp[5], exp[4]} = 32'hc3d2_e1f0;
		send(8);
	end
	endtask
	task t_bare;
	begin
		take(2'b00);
		chk({3'h0, sec_len_reg}, 8'h04);
		hdr(8'd4, irq_slot);
		send(4);
	end
	endtask
	task t_base(input old, input [6:0] e, input [7:0] flags);
	begin
		base_old_layout <= old;
		errs <= e;
		take(2'b11);
		hdr(old ? 8'd8 : 8'd20, 8'h02);
		exp[4] = flags;
		if (!old)
		begin
			exp[5] = 8'h1b;
			exp[9] = 8'h08;
			exp[10] = 8'h08;
		end
		send(old ? 8 : 20);
	end
	endtask
	initial
	begin
		n_mismatch = 0;
		samples_checked = 0;
		tick = 0;
		nrst = 1'b0;
		{irq_valid, irq_from_expansion_unit, base_old_layout, enhanced_diag, frame_req} = 5'h00;
		{irq_kind, irq_record, irq_hw_info, errs, chan_diag_count} = 173'h0;
		{irq_type, irq_slot, irq_spec} = 24'h5a_07_3c;
		stall = 1'b1;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_diag;
		t_replace;
		t_bare;
		t_base(1'b0, 7'h0a, 8'h15);
		enhanced_diag <= 1'b1;
		chan_diag_count <= 4'h3;
		repeat (2) @(posedge sys_clk);
		chk(sec_start_reg, 8'h19);
		t_base(1'b1, 7'h3f, 8'h95);
		t_base(1'b1, 7'h62, 8'h85);
		finish_test;
	end
endmodule // dis_builder_bench
bind dis_builder dis_builder_assertions i_dis_builder_assertions (.sys_clk, .nrst, .irq_valid, .irq_kind,
	.enhanced_diag, .chan_diag_count, .frame_req, .sec_start_reg, .sec_len_reg, .irq_pending_reg,
	.chan_err_type_reg, .chan_err_valid_reg, .busy_reg, .out_valid_reg);
